// File: verilog/bic_top.v
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "bic_map.vh"
// Contract
// - binary filter time programmable 0 to 1000 s
// - filter disabled (zero) after reset
// - changes shorter than filter time ignored
// - value below low limit sets low flag
// - value above high limit sets high flag
// - counter modes add, subtract, quad1, quad4
// - three independent configurable demo inputs
// - demo shape rectangle, triangle or sine
// - demo swings between programmable min and max
// - demo repeats with programmable period
// - rectangle holds max for high-state time
// - triangle rises min to max over rise time
// - each demo has own low/high limits, flags
// - one shared configuration per demo input
module bic_top #(
    parameter TICK_CYCLES = `BIC_TICK_CYC
) (
    // clock and reset
    input wire mclk_in,
    input wire reset_n_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // field pins
    input wire builtin_binary_input_in,
    input wire cnt_a_in,
    input wire cnt_b_in,
    // conditioned results
    output reg filtered_binary_out,
    output reg [3:0] low_alarm_flag_out,
    output reg [3:0] high_alarm_flag_out
);
    localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
    wire [14:0] tick_last = TICK_LAST_W[14:0];

    // ****************************************
    // apb slave
    // ****************************************
    wire acc = psel_in & penable_in;
    wire wr_en = acc & pready_out & pwrite_in & ~pslverr_out;
    reg [31:0] rd_d;
    reg err_d;
    reg [1:0] mode_q;
    reg [19:0] filt_ms_q;
    reg [15:0] cnt_q;
    wire [2:0] pin_w;
    wire [3:0] lo_w;
    wire [3:0] hi_w;
    wire [127:0] lim_w;
    wire [95:0] demo_rd_w;
    wire [47:0] dv_w;
    wire [2:0] dsel = paddr_in[7:5] - 3'h2;
    wire [31:0] stat_w = {20'h00000, high_alarm_flag_out, low_alarm_flag_out,
        3'h0, filtered_binary_out};

    // one wait state: read data is captured from flops on the same edge that pready rises
    always @*
    begin
        rd_d = 32'h00000000;
        err_d = 1'b0;
        if (paddr_in[1:0] != 2'h0)
            err_d = 1'b1;
        else if (paddr_in < `BIC_ADR_LO)
        begin
            case (paddr_in[3:2])
                2'h0: rd_d = {30'h00000000, mode_q};
                2'h1: rd_d = {12'h000, filt_ms_q};
                2'h2: rd_d = stat_w;
                default: rd_d = {{16{cnt_q[15]}}, cnt_q};
            endcase
        end
        else if (paddr_in < `BIC_ADR_END)
            rd_d = paddr_in[5] ? {16'h0000, lim_w[32 * paddr_in[3:2] + 16 +: 16]}
                : {16'h0000, lim_w[32 * paddr_in[3:2] +: 16]};
        else if (paddr_in >= `BIC_ADR_DEMO && paddr_in < `BIC_ADR_DEMO_END
            && paddr_in[4:2] <= `BIC_DW_VALUE)
            rd_d = demo_rd_w[32 * dsel[1:0] +: 32];
        else
            err_d = 1'b1;
    end

    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else if (acc && !pready_out)
        begin
            pready_out <= 1'b1;
            pslverr_out <= err_d;
            prdata_out <= pwrite_in ? 32'h00000000 : rd_d;
        end
        else
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // ****************************************
    // control and filter registers
    // ****************************************
    wire clr_cnt = wr_en && paddr_in == `BIC_ADR_CTRL && pwdata_in[`BIC_CTRL_CLR];

    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            mode_q <= `BIC_CM_ADD;
            filt_ms_q <= `BIC_FILT_RST;
        end
        else if (wr_en)
        begin
            if (paddr_in == `BIC_ADR_CTRL)
                mode_q <= pwdata_in[1:0];
            if (paddr_in == `BIC_ADR_FILT)
                filt_ms_q <= (pwdata_in > {12'h000, `BIC_FILT_MAX_MS})
                    ? `BIC_FILT_MAX_MS : pwdata_in[19:0];
        end
    end

    // ****************************************
    // millisecond tick
    // ****************************************
    // one tick divider paces both the filter and the demo generators
    reg [14:0] div_q;
    reg tick_q;

    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            div_q <= 15'h0000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == tick_last);
            div_q <= (div_q == tick_last) ? 15'h0000 : div_q + 15'h0001;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    wire [2:0] pins_raw = {cnt_b_in, cnt_a_in, builtin_binary_input_in};
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg st_q;
            // a level is taken only once two late stages agree
            always @(posedge mclk_in)
            begin
                if (!reset_n_in)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    st_q <= 1'b0;
                end
                else
                begin
                    s1_q <= pins_raw[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        st_q <= s3_q;
                end
            end
            assign pin_w[g] = st_q;
        end
    endgenerate

    // ****************************************
    // binary input debounce
    // ****************************************
    reg [19:0] fcnt_q;

    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            fcnt_q <= 20'h00000;
            filtered_binary_out <= 1'b0;
        end
        else if (pin_w[0] == filtered_binary_out)
            fcnt_q <= 20'h00000;
        else if (fcnt_q >= filt_ms_q)
        begin
            filtered_binary_out <= pin_w[0];
            fcnt_q <= 20'h00000;
        end
        else if (tick_q)
            fcnt_q <= fcnt_q + 20'h00001;
    end

    // ****************************************
    // counter function
    // ****************************************
    reg [1:0] ab_q;
    reg [15:0] delta;
    wire a_lvl = pin_w[1];
    wire b_lvl = pin_w[2];
    wire a_ch = a_lvl ^ ab_q[0];
    wire b_ch = b_lvl ^ ab_q[1];
    wire a_up = a_ch & a_lvl;
    wire b_up = b_ch & b_lvl;
    // quad4: a edge with a!=b, or b edge with a==b, means a leads b
    wire q_fwd = (a_ch & (a_lvl != b_lvl)) | (b_ch & (a_lvl == b_lvl));

    always @*
    begin
        delta = 16'h0000;
        case (mode_q)
            `BIC_CM_ADD:
                delta = {15'h0000, a_up} + {15'h0000, b_up};
            `BIC_CM_SUB:
                delta = {15'h0000, a_up} - {15'h0000, b_up};
            `BIC_CM_QUAD1:
                if (a_up)
                    delta = b_lvl ? 16'hffff : 16'h0001;
            `BIC_CM_QUAD4:
                if (a_ch ^ b_ch)
                    delta = q_fwd ? 16'h0001 : 16'hffff;
            default:
                delta = 16'h0000;
        endcase
    end

    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            ab_q <= 2'h0;
            cnt_q <= 16'h0000;
        end
        else
        begin
            ab_q <= {b_lvl, a_lvl};
            cnt_q <= clr_cnt ? 16'h0000 : cnt_q + delta;
        end
    end

    // ****************************************
    // demo inputs
    // ****************************************
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_demo
            localparam [31:0] DBLK = g + 2;
            reg [1:0] sh_q;
            reg [15:0] mn_q;
            reg [15:0] mx_q;
            reg [19:0] pr_q;
            reg [19:0] hs_q;
            reg [19:0] rs_q;
            reg [31:0] rd_w;
            wire sel = wr_en && paddr_in[7:5] == DBLK[2:0];
            // one register set per demo: every channel reading it sees the same
            always @(posedge mclk_in)
            begin
                if (!reset_n_in)
                begin
                    sh_q <= `BIC_SH_RECT;
                    mn_q <= `BIC_MIN_RST;
                    mx_q <= `BIC_MAX_RST;
                    pr_q <= `BIC_PER_RST;
                    hs_q <= `BIC_HST_RST;
                    rs_q <= `BIC_RISE_RST;
                end
                else if (sel)
                begin
                    case (paddr_in[4:2])
                        `BIC_DW_SHAPE: sh_q <= pwdata_in[1:0];
                        `BIC_DW_LEVEL:
                        begin
                            mn_q <= pwdata_in[15:0];
                            mx_q <= pwdata_in[31:16];
                        end
                        `BIC_DW_PERIOD: pr_q <= pwdata_in[19:0];
                        `BIC_DW_HIGH: hs_q <= pwdata_in[19:0];
                        `BIC_DW_RISE: rs_q <= pwdata_in[19:0];
                        default: sh_q <= sh_q;
                    endcase
                end
            end
            always @*
            begin
                case (paddr_in[4:2])
                    `BIC_DW_SHAPE: rd_w = {30'h00000000, sh_q};
                    `BIC_DW_LEVEL: rd_w = {mx_q, mn_q};
                    `BIC_DW_PERIOD: rd_w = {12'h000, pr_q};
                    `BIC_DW_HIGH: rd_w = {12'h000, hs_q};
                    `BIC_DW_RISE: rd_w = {12'h000, rs_q};
                    default: rd_w = {16'h0000, dv_w[16 * g +: 16]};
                endcase
            end
            assign demo_rd_w[32 * g +: 32] = rd_w;
            bic_demo_gen u_gen (
                .mclk_in(mclk_in),
                .reset_n_in(reset_n_in),
                .tick_in(tick_q),
                .shape_in(sh_q),
                .min_in(mn_q),
                .max_in(mx_q),
                .period_in(pr_q),
                .high_in(hs_q),
                .rise_in(rs_q),
                .value_out(dv_w[16 * g +: 16])
            );
        end
    endgenerate

    // ****************************************
    // limit alarms
    // ****************************************
    // channel 0 is the counter, channels 1..3 the demo inputs
    wire [63:0] ch_val = {dv_w, cnt_q};
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_alarm
            reg [15:0] lo_q;
            reg [15:0] hi_q;
            localparam [31:0] LO_ADR = `BIC_ADR_LO + 4 * g;
            localparam [31:0] HI_ADR = `BIC_ADR_HI + 4 * g;
            wire [7:0] lo_adr = LO_ADR[7:0];
            wire [7:0] hi_adr = HI_ADR[7:0];
            always @(posedge mclk_in)
            begin
                if (!reset_n_in)
                begin
                    lo_q <= `BIC_LO_RST;
                    hi_q <= `BIC_HI_RST;
                end
                else if (wr_en)
                begin
                    if (paddr_in == lo_adr)
                        lo_q <= pwdata_in[15:0];
                    if (paddr_in == hi_adr)
                        hi_q <= pwdata_in[15:0];
                end
            end
            // limits compare as signed, so negative levels work
            assign lo_w[g] = $signed(ch_val[16 * g +: 16]) < $signed(lo_q);
            assign hi_w[g] = $signed(ch_val[16 * g +: 16]) > $signed(hi_q);
            assign lim_w[32 * g +: 32] = {hi_q, lo_q};
        end
    endgenerate

    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            low_alarm_flag_out <= 4'h0;
            high_alarm_flag_out <= 4'h0;
        end
        else
        begin
            low_alarm_flag_out <= lo_w;
            high_alarm_flag_out <= hi_w;
        end
    end
endmodule // bic_top

// File: verilog/bic_map.vh
`ifndef BIC_MAP_VH
`define BIC_MAP_VH
// ****************************************
// timing
// ****************************************
`define BIC_CLK_HZ 20000000
`define BIC_TICK_US 1000
`define BIC_TICK_CYC ((`BIC_CLK_HZ / 1000000) * `BIC_TICK_US)
`define BIC_FILT_MAX_MS 20'hf4240
`define BIC_FILT_RST 20'h00000
// ****************************************
// register offsets
// ****************************************
`define BIC_ADR_CTRL 8'h00
`define BIC_ADR_FILT 8'h04
`define BIC_ADR_STAT 8'h08
`define BIC_ADR_CNT 8'h0c
`define BIC_ADR_LO 8'h10
`define BIC_ADR_HI 8'h20
`define BIC_ADR_END 8'h30
`define BIC_ADR_DEMO 8'h40
`define BIC_ADR_DEMO_END 8'ha0
`define BIC_DW_SHAPE 3'h0
`define BIC_DW_LEVEL 3'h1
`define BIC_DW_PERIOD 3'h2
`define BIC_DW_HIGH 3'h3
`define BIC_DW_RISE 3'h4
`define BIC_DW_VALUE 3'h5
// ****************************************
// fields and encodings
// ****************************************
`define BIC_CTRL_CLR 4
`define BIC_ST_LO 4
`define BIC_ST_HI 8
`define BIC_CM_ADD 2'h0
`define BIC_CM_SUB 2'h1
`define BIC_CM_QUAD1 2'h2
`define BIC_CM_QUAD4 2'h3
`define BIC_SH_RECT 2'h0
`define BIC_SH_TRI 2'h1
`define BIC_SH_SINE 2'h2
// ****************************************
// reset values
// ****************************************
`define BIC_LO_RST 16'h8000
`define BIC_HI_RST 16'h7fff
`define BIC_MIN_RST 16'h0000
`define BIC_MAX_RST 16'h0064
`define BIC_PER_RST 20'h003e8
`define BIC_HST_RST 20'h001f4
`define BIC_RISE_RST 20'h001f4
`endif

// File: verilog/bic_demo_gen.v
`timescale 1ns/1ns
`include "bic_map.vh"
module bic_demo_gen (
    // clock, reset, millisecond tick
    input wire mclk_in,
    input wire reset_n_in,
    input wire tick_in,
    // shared configuration of one demo input
    input wire [1:0] shape_in,
    input wire [15:0] min_in,
    input wire [15:0] max_in,
    input wire [19:0] period_in,
    input wire [19:0] high_in,
    input wire [19:0] rise_in,
    // generated level
    output reg [15:0] value_out
);
    reg [19:0] t_q;
    wire [20:0] t_nx = {1'b0, t_q} + 21'h000001;
    wire [16:0] span = {max_in[15], max_in} - {min_in[15], min_in};
    wire [19:0] fall = period_in - rise_in;
    wire [19:0] left = period_in - t_q;
    wire [36:0] p_up = span * t_q;
    wire [36:0] p_dn = span * left;
    wire [25:0] ph = (period_in == 20'h00000) ? 26'h0000000 : {t_q, 6'h00} / period_in;
    wire [4:0] k = ph[4] ? (5'h10 - {1'b0, ph[3:0]}) : {1'b0, ph[3:0]};
    reg [7:0] amp;
    reg [7:0] u;
    reg [36:0] off;
    reg [24:0] sprod;
    wire [16:0] sum = {min_in[15], min_in} + off[16:0];
    // quarter sine, 0..127
    always @*
    begin
        case (k)
            5'h00: amp = 8'h00;
            5'h01: amp = 8'h0c;
            5'h02: amp = 8'h19;
            5'h03: amp = 8'h25;
            5'h04: amp = 8'h31;
            5'h05: amp = 8'h3c;
            5'h06: amp = 8'h47;
            5'h07: amp = 8'h51;
            5'h08: amp = 8'h5a;
            5'h09: amp = 8'h62;
            5'h0a: amp = 8'h6a;
            5'h0b: amp = 8'h70;
            5'h0c: amp = 8'h75;
            5'h0d: amp = 8'h7a;
            5'h0e: amp = 8'h7d;
            default: amp = 8'h7f;
        endcase
    end
    // offset above the minimum for the selected shape
    always @*
    begin
        u = ph[5] ? (8'h80 - amp) : (8'h80 + amp);
        // full product width, so large spans do not wrap before the scaling
        sprod = span * u;
        off = 37'h0;
        case (shape_in)
            `BIC_SH_TRI:
            begin
                if (t_q < rise_in)
                    off = p_up / rise_in;
                else if (fall != 20'h00000)
                    off = p_dn / fall;
            end
            `BIC_SH_SINE:
                off = {20'h00000, sprod[24:8]};
            default:
                off = 37'h0;
        endcase
    end
    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            t_q <= 20'h00000;
            value_out <= 16'h0000;
        end
        else
        begin
            if (tick_in)
                t_q <= (t_nx >= {1'b0, period_in}) ? 20'h00000 : t_nx[19:0];
            if (shape_in == `BIC_SH_RECT)
                value_out <= (t_q < high_in) ? max_in : min_in;
            else
                value_out <= sum[15:0];
        end
    end
endmodule // bic_demo_gen

// File: testbench/bic_field.sv
`timescale 1ns/1ns
// ****************************************
// field switch and counter encoder model
// ****************************************
module bic_field (
    // clock
    input wire mclk_in,
    // driven pins
    output reg level_out,
    output reg a_out,
    output reg b_out
);
    initial
    begin
        level_out = 1'b0;
        a_out = 1'b0;
        b_out = 1'b0;
    end
    // hold a level for n edges
    task hold(input logic v, input int n);
        @(posedge mclk_in);
        level_out <= v;
        repeat (n - 1) @(posedge mclk_in);
    endtask
    // real contacts chatter before they settle
    task bounce(input logic v, input int n);
        repeat (3)
        begin
            hold(v, 1);
            hold(!v, 1);
        end
        hold(v, n);
    endtask
    // 4 cycles per level so the pin synchroniser always sees it
    task ab(input logic [1:0] v);
        @(posedge mclk_in);
        {a_out, b_out} <= v;
        repeat (3) @(posedge mclk_in);
    endtask
    task pulses(input int na, input int nb);
        repeat (na)
        begin
            ab(2'b10);
            ab(2'b00);
        end
        repeat (nb)
        begin
            ab(2'b01);
            ab(2'b00);
        end
    endtask
    // forward quadrature: a leads b
    task quad(input int n);
        repeat (n)
        begin
            ab(2'b10);
            ab(2'b11);
            ab(2'b01);
            ab(2'b00);
        end
    endtask
endmodule // bic_field

// File: testbench/bic_top_props.sv
`timescale 1ns/1ns
// ****************************************
// port checker
// ****************************************
module bic_props (
    // clock and reset
    input wire mclk_in,
    input wire reset_n_in,
    // apb
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    // pins and results
    input wire builtin_binary_input_in,
    input wire cnt_a_in,
    input wire cnt_b_in,
    input wire filtered_binary_out,
    input wire [3:0] low_alarm_flag_out,
    input wire [3:0] high_alarm_flag_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_wait;
        (penable_in && !pready_out) ##1 pready_out;
    endsequence
    property p_one_wait;
        s_setup |=> s_wait;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
    property p_rdy_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_rdy_access;
        pready_out |-> psel_in && penable_in;
    endproperty
    a_rdy_access: assert property (p_rdy_access) else $error("pready outside access");
    property p_err_rdy;
        pslverr_out |-> pready_out;
    endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    property p_misalign;
        pready_out && (paddr_in[1:0] != 2'h0) |-> pslverr_out;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
    property p_mapped;
        pready_out && (paddr_in < 8'h30) && (paddr_in[1:0] == 2'h0) |-> !pslverr_out;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_err_zero;
        pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    property p_rst;
        disable iff (1'b0) !reset_n_in |=> !filtered_binary_out && !pready_out
            && low_alarm_flag_out == 4'h0 && high_alarm_flag_out == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    // a change must have been on the pin for two cycles first
    property p_filt_stable;
        $changed(filtered_binary_out) |-> $past(builtin_binary_input_in, 2) == filtered_binary_out
            && $past(builtin_binary_input_in, 3) == filtered_binary_out;
    endproperty
    a_filt_stable: assert property (p_filt_stable) else $error("short pin change passed");
endmodule // bic_props
bind bic_top bic_props u_props (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .builtin_binary_input_in(builtin_binary_input_in), .cnt_a_in(cnt_a_in), .cnt_b_in(cnt_b_in),
    .filtered_binary_out(filtered_binary_out), .low_alarm_flag_out(low_alarm_flag_out),
    .high_alarm_flag_out(high_alarm_flag_out));

// File: testbench/builtin_input_conditioning_tb.sv
`timescale 1ns/1ns
`include "bic_map.vh"
// ****************************************
// self-checking bench
// ****************************************
module builtin_input_conditioning_tb;
    logic mclk_in, reset_n_in, psel_in, penable_in, pwrite_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic pready_out, pslverr_out, pin, pa, pb, filt;
    logic [3:0] lo_f, hi_f;
    logic [40:0] exp_q[$];
    logic [40:0] e;
    logic [15:0] vv[3];
    logic [7:0] base;
    int err_total, compares, na, nb, s, d, m, seed;
    // short tick keeps every millisecond count to a few cycles
    bic_top #(.TICK_CYCLES(8)) u_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .builtin_binary_input_in(pin), .cnt_a_in(pa), .cnt_b_in(pb),
        .filtered_binary_out(filt), .low_alarm_flag_out(lo_f), .high_alarm_flag_out(hi_f));
    bic_field u_field (.mclk_in(mclk_in), .level_out(pin), .a_out(pa), .b_out(pb));
    task stop_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= dt;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        @(posedge mclk_in);
        while (pready_out !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                $display("[ERR] pready exp 1 got 0");
                err_total++;
                stop_test;
            end
            @(posedge mclk_in);
        end
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] dt);
        apb(1'b1, a, dt);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back({1'b0, a, x});
        apb(1'b0, a, 32'h0);
    endtask
    // refused read: error flag with zero data
    task rdx(input logic [7:0] a);
        exp_q.push_back({1'b1, a, 32'h0});
        apb(1'b0, a, 32'h0);
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, ex, got);
        end
    endtask
    // read results leave the queue in issue order
    always @(posedge mclk_in)
    begin
        if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            chk("prdata", e[31:0], prdata_out);
            chk("pslverr", {31'h0, e[40]}, {31'h0, pslverr_out});
        end
    end
    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    initial
    begin
        {reset_n_in, psel_in, penable_in, pwrite_in} = 4'h0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        seed = $urandom(32'h4a939cf4);
        repeat (4) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        rd(`BIC_ADR_FILT, 32'h0);
        rd(`BIC_ADR_STAT, 32'h0);
        rdx(8'h30);
        rdx(8'h05);
        $display("reset test done");
        wr(`BIC_ADR_FILT, 32'hfffff);
        rd(`BIC_ADR_FILT, 32'hf4240);
        wr(`BIC_ADR_FILT, 32'h3);
        u_field.bounce(1'b1, 10);
        u_field.hold(1'b0, 40);
        rd(`BIC_ADR_STAT, 32'h0);
        u_field.bounce(1'b1, 60);
        rd(`BIC_ADR_STAT, 32'h1);
        wr(`BIC_ADR_FILT, 32'h0);
        u_field.hold(1'b0, 10);
        rd(`BIC_ADR_STAT, 32'h0);
        $display("filter test done");
        // demo 0 sits below its low limit, demo 1 above its high limit
        for (s = 0; s < 3; s++)
        begin
            for (d = 0; d < 3; d++)
            begin
                base = `BIC_ADR_DEMO + 8'(d * 32);
                vv[d] = 16'($urandom_range(30000, 100));
                wr(base, 32'(s));
                wr(base + 8'h04, {vv[d], vv[d]});
                wr(base + 8'h08, 32'h4);
                wr(`BIC_ADR_LO + 8'(4 * d + 4), {16'h0, (d == 0) ? vv[d] + 16'h1 : vv[d] - 16'h1});
                wr(`BIC_ADR_HI + 8'(4 * d + 4), {16'h0, (d == 1) ? vv[d] - 16'h1 : vv[d] + 16'h1});
            end
            repeat (80) @(posedge mclk_in);
            for (d = 0; d < 3; d++)
                rd(`BIC_ADR_DEMO + 8'(d * 32 + 20), {16'h0, vv[d]});
            rd(`BIC_ADR_STAT, 32'h420);
        end
        // a zero period parks the phase at its start, so each shape shows a fixed level
        wr(`BIC_ADR_DEMO + 8'h08, 32'h0);
        wr(`BIC_ADR_DEMO + 8'h04, 32'h70001000);
        wr(`BIC_ADR_DEMO + 8'h0c, 32'h0);
        wr(`BIC_ADR_DEMO, 32'(`BIC_SH_RECT));
        rd(`BIC_ADR_DEMO + 8'h14, 32'h1000);
        wr(`BIC_ADR_DEMO + 8'h0c, 32'h1);
        rd(`BIC_ADR_DEMO + 8'h14, 32'h7000);
        wr(`BIC_ADR_DEMO, 32'(`BIC_SH_TRI));
        rd(`BIC_ADR_DEMO + 8'h14, 32'h1000);
        wr(`BIC_ADR_DEMO, 32'(`BIC_SH_SINE));
        rd(`BIC_ADR_DEMO + 8'h14, 32'h4000);
        rd(`BIC_ADR_DEMO + 8'h04, 32'h70001000);
        $display("demo test done");
        for (m = 0; m < 4; m++)
        begin
            na = $urandom_range(4, 1);
            nb = $urandom_range(4, 1);
            wr(`BIC_ADR_CTRL, 32'h10 | 32'(m));
            if (m == 3)
                u_field.quad(na);
            else
                u_field.pulses(na, nb);
            repeat (10) @(posedge mclk_in);
            case (m)
                0: rd(`BIC_ADR_CNT, 32'(na + nb));
                1: rd(`BIC_ADR_CNT, 32'(na - nb));
                2: rd(`BIC_ADR_CNT, 32'(na));
                default: rd(`BIC_ADR_CNT, 32'(4 * na));
            endcase
        end
        $display("counter test done");
        repeat (5) @(posedge mclk_in);
        stop_test;
    end
endmodule // builtin_input_conditioning_tb
